/* File: rtl/boot_loader_defines.svh */
`ifndef BOOT_LOADER_DEFINES_SVH
`define BOOT_LOADER_DEFINES_SVH

`define SEC_JTAG_OFF_BIT     0
`define SEC_LINK_OFF_BIT     1
`define SEC_SECURE_BOOT_BIT  5
`define SEC_REDUNDANT_BIT    7
`define SEC_LOCK_LO_BIT      8
`define SEC_MASTER_LOCK_BIT  12
`define SEC_JTAG_OTP_OFF_BIT 13
`define SEC_GP_LO            15
`define SEC_GP_HI            21
`define SEC_UID_LO           22
`define SEC_UID_HI           31

`define CRC_POLY      32'hEDB88320
`define CRC_INIT      32'hFFFFFFFF
`define CRC_BYPASS    32'h0D15AB1E

`define OTP_SECTORS   4
`define OTP_ROWS      512
`define OTP_SEC_ROW   11'h7FF

`define ADDR_SECURITY 8'h00
`define ADDR_CONTROL  8'h04
`define ADDR_STATUS   8'h08
`define ADDR_LENGTH   8'h0C
`define ADDR_CRC      8'h10
`define ADDR_PROG     8'h14

`define CLK_MHZ       25
`define BOOT_DELAY_US 15
`define BOOT_DELAY_CYC (`BOOT_DELAY_US * `CLK_MHZ)

`endif

/* File: rtl/boot_loader_pkg.sv */
package boot_loader_pkg;

  typedef enum logic [1:0] {
    SRC_FLASH,
    SRC_OTP
  } boot_src_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } byte_beat_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [31:0] data;
  } ram_req_t;

  typedef struct packed {
    logic       jtag_off;
    logic       link_off;
    logic       redundant_rows;
    logic       jtag_otp_off;
    logic [3:0] sector_prog_ok;
  } guard_t;

endpackage

/* File: rtl/secure_boot_image_loader.sv */
// Function
// - Pull-downs on all GPIOs while reset low.
// - Boot starts 15-150 us after reset release.
// - Security bit 5 picks OTP, else flash.
// - Image: length, s*4 bytes, check word.
// - Bypass word 0x0D15AB1E skips CRC check.
// - Length and check word are LSB first.
// - Load from RAM base, start there.
// - CRC covers length and program bytes.
// - CRC uses reflected polynomial 0xEDB88320.
// - CRC starts all ones, result inverted.
// - Security word loaded from OTP first.
// - Remaining OTP copied to SRAM, run first.
// - OTP is four sectors of 512 words.
// - Bit 0 disables JTAG access.
// - Bit 1 blocks other tiles via switch.
// - Bit 5 boots from OTP address 0.
// - Bit 7 enables redundant OTP rows.
// - Bits 8-11 lock sectors 0-3.
// - Bit 12 blocks all OTP programming.
// - Bit 13 blocks JTAG OTP access.
// - Upper bits hold user fields.
`timescale 1ns/1ps
`include "boot_loader_defines.svh"

module secure_boot_image_loader (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Pad control
  output logic             gpio_pulldown_en,
  // Boot flash byte stream
  output logic             flash_req,
  input  wire logic        flash_byte_valid,
  input  wire logic [7:0]  flash_byte,
  // OTP read port
  output logic             otp_rd,
  output logic [10:0]      otp_addr,
  input  wire logic        otp_rd_valid,
  input  wire logic [31:0] otp_rd_data,
  // OTP programming request and grant
  input  wire logic        otp_prog_req,
  input  wire logic [10:0] otp_prog_addr,
  output logic             otp_prog_grant,
  output logic             otp_prog_reject,
  // JTAG OTP access request and grant
  input  wire logic        jtag_otp_req,
  output logic             jtag_otp_grant,
  // RAM write port
  output logic             ram_we,
  output logic [15:0]      ram_addr,
  output logic [31:0]      ram_wdata,
  // Processor start
  output logic             cpu_start,
  output logic [15:0]      cpu_start_addr,
  // Security outputs
  output logic             jtag_disable,
  output logic             link_disable,
  output logic             otp_redundant_en,
  output logic [9:0]       jtag_user_id,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef enum logic [3:0] {
    ST_DELAY, ST_SEC_RD, ST_SEC_WAIT, ST_OTP_RD, ST_OTP_WAIT,
    ST_LEN, ST_PROG, ST_CHECK, ST_VERIFY, ST_RUN, ST_FAIL
  } state_t;

  localparam logic [15:0] DELAY_CYC = 16'(`BOOT_DELAY_CYC);

  state_t                  state_r;
  // OTP words arrive one read at a time, so the consumer state is parked here
  // while the read is in flight and resumed when the word comes back.
  state_t                  ret_r;
  logic [15:0]             delay_r;
  logic [31:0]             sec_r;
  logic                    sec_loaded_r;
  boot_loader_pkg::boot_src_t src_r;
  logic [31:0]             len_r;
  logic [31:0]             word_r;
  logic [1:0]              bidx_r;
  logic [15:0]             waddr_r;
  logic [31:0]             crc_r;
  logic [31:0]             check_r;
  logic                    crc_bad_r;
  logic                    autostart_r;
  logic                    kick_r;
  logic [31:0]             gp_sw_r;
  boot_loader_pkg::guard_t guard;

  // Reflected CRC-32 update over one byte, shared by both boot sources.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] x;
    x = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 4; i++) begin
      x = crc_byte(x, w[8*i +: 8]);
    end
    return x;
  endfunction

  assign guard.jtag_off       = sec_r[`SEC_JTAG_OFF_BIT];
  assign guard.link_off       = sec_r[`SEC_LINK_OFF_BIT];
  assign guard.redundant_rows = sec_r[`SEC_REDUNDANT_BIT];
  assign guard.jtag_otp_off   = sec_r[`SEC_JTAG_OTP_OFF_BIT];
  assign guard.sector_prog_ok = ~sec_r[`SEC_LOCK_LO_BIT +: 4];

  // Pads are pulled down from reset until the start delay ends and the security row read begins.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_pulldown_en <= 1'b1;
    end else begin
      gpio_pulldown_en <= (state_r == ST_DELAY);
    end
  end

  logic        fbyte;
  logic [31:0] fword;
  assign fbyte = (src_r == boot_loader_pkg::SRC_FLASH) && flash_byte_valid;
  assign fword = {flash_byte, word_r[31:8]};

  // Boot sequencer. Supply settling before reset release is the board's duty.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_DELAY;
      ret_r        <= ST_LEN;
      delay_r      <= 16'h0000;
      sec_r        <= 32'h00000000;
      sec_loaded_r <= 1'b0;
      src_r        <= boot_loader_pkg::SRC_FLASH;
      len_r        <= 32'h00000000;
      word_r       <= 32'h00000000;
      bidx_r       <= 2'h0;
      waddr_r      <= 16'h0000;
      crc_r        <= `CRC_INIT;
      check_r      <= 32'h00000000;
      crc_bad_r    <= 1'b0;
      otp_rd       <= 1'b0;
      otp_addr     <= 11'h000;
      flash_req    <= 1'b0;
      ram_we       <= 1'b0;
      ram_addr     <= 16'h0000;
      ram_wdata    <= 32'h00000000;
      cpu_start    <= 1'b0;
    end else begin
      otp_rd <= 1'b0;
      ram_we <= 1'b0;
      unique case (state_r)
        ST_DELAY: begin
          delay_r <= delay_r + 16'h0001;
          if (delay_r == DELAY_CYC - 16'h0001) begin
            state_r <= ST_SEC_RD;
          end
        end
        ST_SEC_RD: begin
          otp_rd   <= 1'b1;
          otp_addr <= `OTP_SEC_ROW;
          state_r  <= ST_SEC_WAIT;
        end
        ST_SEC_WAIT: begin
          if (otp_rd_valid) begin
            sec_r        <= otp_rd_data;
            sec_loaded_r <= 1'b1;
            crc_r        <= `CRC_INIT;
            bidx_r       <= 2'h0;
            if (otp_rd_data[`SEC_SECURE_BOOT_BIT]) begin
              src_r    <= boot_loader_pkg::SRC_OTP;
              otp_addr <= 11'h000;
              ret_r    <= ST_LEN;
              state_r  <= ST_OTP_RD;
            end else begin
              src_r     <= boot_loader_pkg::SRC_FLASH;
              flash_req <= 1'b1;
              state_r   <= ST_LEN;
            end
          end
        end
        ST_OTP_RD: begin
          otp_rd  <= 1'b1;
          state_r <= ST_OTP_WAIT;
        end
        ST_OTP_WAIT: begin
          if (otp_rd_valid) begin
            word_r   <= otp_rd_data;
            otp_addr <= otp_addr + 11'h001;
            state_r  <= ret_r;
          end
        end
        ST_LEN, ST_PROG, ST_CHECK: begin
          if (src_r == boot_loader_pkg::SRC_OTP && state_r != ST_OTP_WAIT) begin
            // Whole words come from OTP; each one is then routed like a flash word.
            if (state_r == ST_LEN) begin
              len_r   <= word_r;
              crc_r   <= crc_word(crc_r, word_r);
              waddr_r <= 16'h0000;
              ret_r   <= (word_r == 32'h00000000) ? ST_CHECK : ST_PROG;
              state_r <= ST_OTP_RD;
            end else if (state_r == ST_PROG) begin
              ram_we    <= 1'b1;
              ram_addr  <= waddr_r;
              ram_wdata <= word_r;
              crc_r     <= crc_word(crc_r, word_r);
              waddr_r   <= waddr_r + 16'h0004;
              len_r     <= len_r - 32'h00000001;
              state_r   <= ST_OTP_RD;
              ret_r     <= ST_PROG;
              if (len_r == 32'h00000001) begin
                ret_r <= ST_CHECK;
              end
            end else begin
              check_r <= word_r;
              state_r <= ST_VERIFY;
            end
          end else if (fbyte) begin
            word_r <= fword;
            bidx_r <= bidx_r + 2'h1;
            if (state_r != ST_CHECK) begin
              crc_r <= crc_byte(crc_r, flash_byte);
            end
            if (bidx_r == 2'h3) begin
              if (state_r == ST_LEN) begin
                len_r   <= fword;
                waddr_r <= 16'h0000;
                state_r <= (fword == 32'h00000000) ? ST_CHECK : ST_PROG;
              end else if (state_r == ST_PROG) begin
                ram_we    <= 1'b1;
                ram_addr  <= waddr_r;
                ram_wdata <= fword;
                waddr_r   <= waddr_r + 16'h0004;
                len_r     <= len_r - 32'h00000001;
                if (len_r == 32'h00000001) begin
                  state_r <= ST_CHECK;
                end
              end else begin
                check_r   <= fword;
                flash_req <= 1'b0;
                state_r   <= ST_VERIFY;
              end
            end
          end
        end
        ST_VERIFY: begin
          if (check_r == `CRC_BYPASS || check_r == ~crc_r) begin
            crc_bad_r <= 1'b0;
            state_r   <= ST_RUN;
          end else begin
            crc_bad_r <= 1'b1;
            state_r   <= ST_FAIL;
          end
        end
        ST_RUN: begin
          cpu_start <= autostart_r | kick_r;
        end
        ST_FAIL: begin
          cpu_start <= 1'b0;
        end
        default: begin
          state_r <= ST_FAIL;
        end
      endcase
    end
  end

  assign cpu_start_addr = 16'h0000;

  // Security-gated outputs, valid once the security word is in.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jtag_disable     <= 1'b1;
      link_disable     <= 1'b1;
      otp_redundant_en <= 1'b0;
      jtag_user_id     <= 10'h000;
      otp_prog_grant   <= 1'b0;
      otp_prog_reject  <= 1'b0;
      jtag_otp_grant   <= 1'b0;
    end else begin
      // Access stays closed until the word is known, so nothing leaks early.
      jtag_disable     <= !sec_loaded_r || guard.jtag_off;
      link_disable     <= !sec_loaded_r || guard.link_off;
      otp_redundant_en <= sec_loaded_r && guard.redundant_rows;
      jtag_user_id     <= sec_r[`SEC_UID_HI:`SEC_UID_LO];
      otp_prog_grant   <= otp_prog_req && sec_loaded_r
                          && !sec_r[`SEC_MASTER_LOCK_BIT]
                          && otp_prog_addr != `OTP_SEC_ROW
                          && guard.sector_prog_ok[otp_prog_addr[10:9]];
      otp_prog_reject  <= otp_prog_req && !(sec_loaded_r
                          && !sec_r[`SEC_MASTER_LOCK_BIT]
                          && otp_prog_addr != `OTP_SEC_ROW
                          && guard.sector_prog_ok[otp_prog_addr[10:9]]);
      jtag_otp_grant   <= jtag_otp_req && sec_loaded_r
                          && !guard.jtag_otp_off && !guard.jtag_off;
    end
  end

  // AXI4-Lite write path.
  logic aw_hit_r;
  logic w_hit_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        w_strb0_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_hit_r      <= 1'b0;
      w_hit_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb0_r     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      autostart_r   <= 1'b1;
      kick_r        <= 1'b0;
      gp_sw_r       <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hit_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hit_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb0_r    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (aw_hit_r && w_hit_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (aw_addr_r == `ADDR_CONTROL && w_strb0_r) begin
          autostart_r <= w_data_r[0];
          kick_r      <= w_data_r[1];
        end else if (aw_addr_r != `ADDR_SECURITY && aw_addr_r != `ADDR_STATUS
                     && aw_addr_r != `ADDR_LENGTH && aw_addr_r != `ADDR_CRC
                     && aw_addr_r != `ADDR_PROG) begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_hit_r      <= 1'b0;
        w_hit_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        unique case (s_axi_araddr)
          `ADDR_SECURITY: s_axi_rdata <= sec_r;
          `ADDR_CONTROL:  s_axi_rdata <= {30'h00000000, kick_r, autostart_r};
          `ADDR_STATUS:   s_axi_rdata <= {24'h000000, crc_bad_r, cpu_start,
                                          sec_loaded_r, src_r[0], state_r};
          `ADDR_LENGTH:   s_axi_rdata <= len_r;
          `ADDR_CRC:      s_axi_rdata <= ~crc_r;
          `ADDR_PROG:     s_axi_rdata <= {16'h0000, waddr_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: test/secure_boot_image_loader_assertions.sv */
`timescale 1ns/1ps
`include "boot_loader_defines.svh"
module secure_boot_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Watched ports
  input wire logic        gpio_pulldown_en,
  input wire logic        flash_req,
  input wire logic        otp_rd,
  input wire logic        otp_prog_req,
  input wire logic [10:0] otp_prog_addr,
  input wire logic        otp_prog_grant,
  input wire logic        otp_prog_reject,
  input wire logic        jtag_otp_req,
  input wire logic        jtag_otp_grant,
  input wire logic        jtag_disable,
  input wire logic        ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic        cpu_start,
  input wire logic [15:0] cpu_start_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [15:0] cnt_r;
  logic        seen_r;
  logic [15:0] last_r;
  // The counter saturates so that it never wraps back into the quiet window.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r != 16'hFFFF) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
      last_r <= 16'h0000;
    end else if (ram_we) begin
      seen_r <= 1'b1;
      last_r <= ram_addr;
    end
  end
  sequence sec_row_ask;
    otp_prog_req && otp_prog_addr == `OTP_SEC_ROW;
  endsequence
  sequence boot_go;
    $rose(cpu_start);
  endsequence
  pull_down_a: assert property (cnt_r == 16'h0000 |-> gpio_pulldown_en)
    else $error("Pull-downs off right after reset release.");
  quiet_delay_a: assert property (cnt_r < `BOOT_DELAY_CYC - 4 |-> !otp_rd && !flash_req)
    else $error("Boot media touched before the start delay.");
  prog_answer_a: assert property (otp_prog_req |=> otp_prog_grant ^ otp_prog_reject)
    else $error("Programming request not answered exactly once.");
  sec_row_a: assert property (sec_row_ask |=> otp_prog_reject)
    else $error("Security row programming granted.");
  jtag_block_a: assert property (jtag_otp_req && jtag_disable |=> !jtag_otp_grant)
    else $error("Scan access granted while disabled.");
  first_word_a: assert property (ram_we && !seen_r |-> ram_addr == 16'h0000)
    else $error("First program word not at RAM base.");
  word_step_a: assert property (ram_we && seen_r |-> ram_addr == last_r + 16'h0004)
    else $error("Program words not consecutive.");
  start_addr_a: assert property (cpu_start |-> cpu_start_addr == 16'h0000)
    else $error("Start address is not the RAM base.");
  start_hold_a: assert property (boot_go |=> cpu_start [*4])
    else $error("Processor start dropped.");
endmodule

bind secure_boot_image_loader secure_boot_checker i_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .gpio_pulldown_en(gpio_pulldown_en),
  .flash_req(flash_req), .otp_rd(otp_rd), .otp_prog_req(otp_prog_req),
  .otp_prog_addr(otp_prog_addr), .otp_prog_grant(otp_prog_grant),
  .otp_prog_reject(otp_prog_reject), .jtag_otp_req(jtag_otp_req),
  .jtag_otp_grant(jtag_otp_grant), .jtag_disable(jtag_disable), .ram_we(ram_we),
  .ram_addr(ram_addr), .cpu_start(cpu_start), .cpu_start_addr(cpu_start_addr)
);

/* File: test/boot_media_model.sv */
`timescale 1ns/1ps
`include "boot_loader_defines.svh"
module boot_media_model (
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         rst_n,
  // Flash byte stream
  input wire logic         flash_req,
  output logic             flash_byte_valid,
  output logic [7:0]       flash_byte,
  // OTP read port
  input wire logic         otp_rd,
  input wire logic [10:0]  otp_addr,
  output logic             otp_rd_valid,
  output logic [31:0]      otp_rd_data
);
  logic [7:0]  img [$];
  logic [31:0] sec_word;
  logic        slow;
  logic        tick_r;
  int          pos;
  // Between beats the byte lines flip, so a stale byte can never pass for a fresh one.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 0;
      tick_r <= 1'b0;
      flash_byte_valid <= 1'b0;
      flash_byte <= 8'h00;
    end else begin
      tick_r <= ~tick_r;
      if (flash_req && pos < img.size() && (!slow || tick_r)) begin
        flash_byte_valid <= 1'b1;
        flash_byte <= img[pos];
        pos <= pos + 1;
      end else begin
        flash_byte_valid <= 1'b0;
        flash_byte <= ~flash_byte;
      end
    end
  end
  // Only the security row is programmed; every other row reads blank.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      otp_rd_valid <= 1'b0;
      otp_rd_data <= 32'h0000_0000;
    end else begin
      otp_rd_valid <= otp_rd;
      if (otp_rd) begin
        otp_rd_data <= (otp_addr == `OTP_SEC_ROW) ? sec_word : 32'h0000_0000;
      end else begin
        otp_rd_data <= ~otp_rd_data;
      end
    end
  end
endmodule

/* File: test/secure_boot_image_loader_tb_top.sv */
`timescale 1ns/1ps
module secure_boot_image_loader_tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, flash_byte_valid, otp_rd_valid, otp_prog_req = 1'b0;
  logic jtag_otp_req = 1'b0, flash_req, otp_rd, ram_we, cpu_start, jtag_disable, link_disable;
  logic otp_redundant_en, otp_prog_grant, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic jtag_otp_grant, otp_prog_reject, grant_exp;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  flash_byte, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [10:0] otp_addr, otp_prog_addr = 11'h000;
  logic [31:0] otp_rd_data, ram_wdata, s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [15:0] ram_addr, cpu_start_addr;
  logic [9:0]  jtag_user_id;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] seed = 32'h082F, exp_q [$], ram_q [$];
  int          n_errors = 0, samples_checked = 0;
  initial forever #20 clk_sys = ~clk_sys;
  secure_boot_image_loader i_secure_boot_image_loader (.clk_sys(clk_sys), .rst_n(rst_n),
    .gpio_pulldown_en(), .flash_req(flash_req), .flash_byte_valid(flash_byte_valid),
    .flash_byte(flash_byte), .otp_rd(otp_rd), .otp_addr(otp_addr),
    .otp_rd_valid(otp_rd_valid), .otp_rd_data(otp_rd_data), .otp_prog_req(otp_prog_req),
    .otp_prog_addr(otp_prog_addr), .otp_prog_grant(otp_prog_grant),
    .otp_prog_reject(otp_prog_reject),
    .jtag_otp_req(jtag_otp_req), .jtag_otp_grant(jtag_otp_grant), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .cpu_start(cpu_start),
    .cpu_start_addr(cpu_start_addr), .jtag_disable(jtag_disable),
    .link_disable(link_disable), .otp_redundant_en(otp_redundant_en),
    .jtag_user_id(jtag_user_id), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  boot_media_model i_boot_media_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .flash_req(flash_req), .flash_byte_valid(flash_byte_valid), .flash_byte(flash_byte),
    .otp_rd(otp_rd), .otp_addr(otp_addr), .otp_rd_valid(otp_rd_valid),
    .otp_rd_data(otp_rd_data));
  always @(posedge clk_sys) if (ram_we === 1'b1) ram_q.push_back(ram_wdata);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Bit-serial reflected update; word bits go in from bit 0, i.e. bytes low first.
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
    for (int i = 0; i < 32; i++) c = (c >> 1) ^ ((c[0] ^ w[i]) ? 32'hEDB88320 : 32'h0);
    return c;
  endfunction
  task automatic put_word(input logic [31:0] w);
    for (int b = 0; b < 4; b++) i_boot_media_model.img.push_back(w[8*b+:8]);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw = 1'b1, w = 1'b1;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(!aw && !w && s_axi_bvalid)) begin
      @(posedge clk_sys);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar = 1'b1;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!(!ar && s_axi_rvalid)) begin
      @(posedge clk_sys);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    close_out;
  end
  initial begin
    logic [31:0] sec, c, w, d;
    logic [1:0]  r;
    int          n, kind;
    for (int t = 0; t < 4; t++) begin
      // Corner words first: all features off, then every lock set; flash boot in all.
      sec = (t == 0) ? 32'h0 : (t == 1) ? 32'hFFFF_FFDF : rnd() & 32'hFFFF_FFDF;
      kind = (t == 1) ? 1 : (t == 2) ? 2 : 0;
      n = (t == 1) ? 0 : 32'(rnd() % 5) + 1;
      i_boot_media_model.sec_word = sec;
      i_boot_media_model.slow = t[0];
      i_boot_media_model.img.delete();
      exp_q.delete();
      ram_q.delete();
      c = crc_word(32'hFFFF_FFFF, n);
      put_word(n);
      for (int i = 0; i < n; i++) begin
        w = rnd();
        exp_q.push_back(w);
        c = crc_word(c, w);
        put_word(w);
      end
      put_word(kind == 1 ? 32'h0D15AB1E : kind == 2 ? ~c ^ 32'h1 : ~c);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      d = 32'h0;
      for (int k = 0; k < 400 && !(d[7] | d[6]); k++) axi_rd(8'h08, d, r);
      check(d[7:4], {kind == 2, kind != 2, 1'b1, 1'b0});
      check(cpu_start, kind != 2);
      check(ram_q.size(), n);
      foreach (exp_q[i]) check(ram_q[i], exp_q[i]);
      axi_rd(8'h10, d, r);
      if (kind != 1) check(d, ~c);
      axi_wr(8'h00, rnd(), r);
      check(r, 2'h0);
      axi_rd(8'h00, d, r);
      check(d, sec);
      check({jtag_user_id, otp_redundant_en, link_disable, jtag_disable},
            {sec[31:22], sec[7], sec[1], sec[0]});
      axi_rd(8'h40, d, r);
      check(r, 2'h2);
      for (int s = 0; s < 6; s++) begin
        @(posedge clk_sys);
        otp_prog_req <= (s < 5);
        jtag_otp_req <= (s == 5);
        otp_prog_addr <= (s < 4) ? {2'(s), 9'(rnd())} : 11'h7FF;
        @(posedge clk_sys);
        otp_prog_req <= 1'b0;
        jtag_otp_req <= 1'b0;
        @(posedge clk_sys);
        grant_exp = s < 4 && !sec[8+s] && !sec[12] && otp_prog_addr != 11'h7FF;
        if (s < 5) check(otp_prog_grant, grant_exp);
        if (s < 5) check(otp_prog_reject, !grant_exp);
        else check(jtag_otp_grant, !sec[13] && !sec[0]);
      end
      $display("Test %0d done", t);
    end
    close_out;
  end
endmodule
